// ---- test/quad_rate_sram_port_timing_tb.sv ----
`timescale 1ns/1ps
module quad_rate_sram_port_timing_tb;
  localparam logic [71:0] pat_a = 72'hA1B2C3D4E5F6071829;
  localparam logic [71:0] pat_b = 72'h3C4D5E6F708192A3B4;
  localparam logic [71:0] pat_c = 72'h0F1E2D3C4B5A697887;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic dll_off = 1'b0; // Strap, caught once after reset
  logic single_clk = 1'b0; // Strap, caught once after reset
  logic rd_req = 1'b0;
  logic [7:0] rd_addr = 8'h00;
  logic wr_req = 1'b0;
  logic [7:0] wr_addr = 8'h00;
  logic [71:0] wr_data = 72'h0;
  logic [7:0] wr_byte_en = 8'h00;
  logic rd_ready, rd_valid, wr_ready, locked, lat_mode, clk_mode, rd_ign, wr_ign;
  logic rd_ign2, wr_ign2;
  logic [71:0] rd_data;
  int fail_count = 0;
  int num_checks = 0;
  int cyc; // Cycles since reset release
  logic ign_seen = 1'b0; // Sticky: the link device dropped a request
  sram_port_if link ();
  sram_port_if fault (); // Driven by hand to break the controller's rules
  sram_device_end sram_device_end_i (.ref_clk(ref_clk), .rst_n(rst_n), .pins(link.dev),
    .dll_locked(locked), .single_cycle_latency_mode(lat_mode), .single_clock_mode(clk_mode),
    .read_ignored(rd_ign), .write_ignored(wr_ign));
  sram_ctrl_end sram_ctrl_end_i (.ref_clk(ref_clk), .rst_n(rst_n), .pins(link.ctl),
    .dll_off(dll_off), .single_clk(single_clk), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_ready(rd_ready), .rd_data(rd_data), .rd_valid(rd_valid), .wr_req(wr_req),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_byte_en(wr_byte_en), .wr_ready(wr_ready));
  sram_device_end sram_device_end_i2 (.ref_clk(ref_clk), .rst_n(rst_n), .pins(fault.dev),
    .dll_locked(), .single_cycle_latency_mode(), .single_clock_mode(),
    .read_ignored(rd_ign2), .write_ignored(wr_ign2));
  sram_port_sva sram_port_sva_i (.ref_clk(ref_clk), .rst_n(rst_n), .k_rise(link.k_rise),
    .kb_rise(link.kb_rise), .c_rise(link.c_rise), .cb_rise(link.cb_rise),
    .c_strap(link.c_strap), .dll_disable_n(link.dll_disable_n),
    .read_port_select_n(link.read_port_select_n),
    .write_port_select_n(link.write_port_select_n),
    .byte_write_select_n(link.byte_write_select_n), .q_oe(link.q_oe));
  always #20 ref_clk = ~ref_clk;
  // Cycle count drives the lock timing checks
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) cyc <= 0;
    else cyc <= cyc + 1;
  end
  // The controller end never breaks the spacing, so no drop may ever show
  always @(posedge ref_clk) begin
    if (rst_n && (rd_ign || wr_ign)) ign_seen <= 1'b1;
  end
  // Free-running K pair on the faulty link; the C pair is driven in step with it
  always @(negedge ref_clk) begin
    fault.k_rise <= ~fault.k_rise;
    fault.kb_rise <= fault.k_rise;
    fault.c_rise <= ~fault.k_rise;
    fault.cb_rise <= fault.k_rise;
  end
  initial begin
    fault.k_rise = 1'b1;
    fault.kb_rise = 1'b0;
    fault.c_rise = 1'b1;
    fault.cb_rise = 1'b0;
    fault.c_strap = 1'b0;
    fault.dll_disable_n = 1'b1;
    fault.addr = 8'h12;
    fault.read_port_select_n = 1'b1;
    fault.write_port_select_n = 1'b1;
    fault.byte_write_select_n = 2'h3;
    fault.d = 18'h0;
  end
  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Handshake wait: request held until the edge that sees ready high
  task automatic do_write(input logic [7:0] a, input logic [71:0] v, input logic [7:0] be);
    int n;
    logic ok;
    @(negedge ref_clk);
    wr_req = 1'b1;
    wr_addr = a;
    wr_data = v;
    wr_byte_en = be;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      ok = wr_ready;
    end while (ok !== 1'b1 && n < 20);
    check(ok, 1'b1);
    @(negedge ref_clk);
    wr_req = 1'b0;
    repeat (8) @(negedge ref_clk); // Array holds the burst after t+5
  endtask : do_write
  task automatic do_read(input logic [7:0] a, input int lat, output logic [71:0] got);
    int n;
    logic ok;
    @(negedge ref_clk);
    rd_req = 1'b1;
    rd_addr = a;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      ok = rd_ready;
    end while (ok !== 1'b1 && n < 20);
    check(ok, 1'b1);
    @(negedge ref_clk);
    rd_req = 1'b0;
    n = 1;
    while (rd_valid !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    check(n, lat + 5);
    got = rd_data;
  endtask : do_read
  task automatic t_burst();
    logic [71:0] got;
    do_write(8'h5A, pat_a, 8'hFF);
    do_write(8'h5B, pat_b, 8'hFF);
    do_read(8'h5A, 3, got);
    check(got, pat_a);
    do_read(8'h5B, 3, got);
    check(got, pat_b);
  endtask : t_burst
  // Cleared lanes keep old contents, one enable per nine-bit lane
  task automatic t_lanes();
    logic [71:0] e, got;
    for (int j = 0; j < 8; j++) e[9*j+:9] = (8'h96 >> j) & 1 ? pat_c[9*j+:9] : pat_a[9*j+:9];
    do_write(8'h5A, pat_c, 8'h96);
    do_read(8'h5A, 3, got);
    check(got, e);
  endtask : t_lanes
  // Both ports asked at once from idle: read wins, write at next decision
  task automatic t_arbit();
    int rc, wc, n;
    logic [71:0] got;
    rc = 0;
    wc = 0;
    @(negedge ref_clk);
    rd_req = 1'b1;
    rd_addr = 8'h5B;
    wr_req = 1'b1;
    wr_addr = 8'h33;
    wr_data = pat_c;
    wr_byte_en = 8'hFF;
    for (n = 1; n < 30 && (rc == 0 || wc == 0); n++) begin
      @(posedge ref_clk);
      if (rc == 0 && rd_ready === 1'b1) rc = n;
      if (wc == 0 && wr_ready === 1'b1) wc = n;
      @(negedge ref_clk);
      if (rc != 0) rd_req = 1'b0;
      if (wc != 0) wr_req = 1'b0;
    end
    check(rc > 0, 1'b1);
    check(wc - rc, 2);
    n = 0;
    while (rd_valid !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    check(rd_data, pat_b);
    repeat (8) @(negedge ref_clk);
    do_read(8'h33, 3, got);
    check(got, pat_c);
  endtask : t_arbit
  // Faulty controller: both selects from idle, then reads on adjacent K rises
  task automatic t_fault();
    @(negedge ref_clk);
    while (fault.k_rise !== 1'b0) @(negedge ref_clk);
    fault.read_port_select_n = 1'b0;
    fault.write_port_select_n = 1'b0;
    @(negedge ref_clk);
    fault.read_port_select_n = 1'b1;
    fault.write_port_select_n = 1'b1;
    check({rd_ign2, wr_ign2}, 2'h1);
    // Odd wait keeps the next select on a K rise
    repeat (7) @(negedge ref_clk);
    fault.read_port_select_n = 1'b0;
    @(negedge ref_clk);
    fault.read_port_select_n = 1'b1;
    check(rd_ign2, 1'b0);
    // Both selects right after a read: the write takes this edge
    @(negedge ref_clk);
    fault.read_port_select_n = 1'b0;
    fault.write_port_select_n = 1'b0;
    @(negedge ref_clk);
    fault.read_port_select_n = 1'b1;
    fault.write_port_select_n = 1'b1;
    check(rd_ign2, 1'b1);
    check(wr_ign2, 1'b0);
  endtask : t_fault
  // Lock after 1024 counted K rises, never while the loop is off
  task automatic t_lock();
    while (cyc < 2044) @(negedge ref_clk);
    check(locked, 1'b0);
    while (cyc < 2052) @(negedge ref_clk);
    check(locked, !dll_off);
  endtask : t_lock
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  initial begin
    logic [71:0] got;
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    check({lat_mode, clk_mode}, 2'h0);
    t_burst();
    t_lanes();
    t_arbit();
    t_fault();
    t_lock();
    // Second run with the loop off and a single clock pair
    rst_n = 1'b0;
    dll_off = 1'b1;
    single_clk = 1'b1;
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    check({lat_mode, clk_mode}, 2'h3);
    do_write(8'h44, pat_b, 8'hFF);
    do_read(8'h44, 2, got);
    check(got, pat_b);
    t_lock();
    check(ign_seen, 1'b0);
    summarize();
  end
  // Watchdog well beyond the two lock waits
  initial begin
    #240000;
    fail_count++;
    summarize();
  end
endmodule : quad_rate_sram_port_timing_tb

// ---- test/sram_port_sva.sv ----
`timescale 1ns/1ps
module sram_port_sva (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic k_rise,
  input wire logic kb_rise,
  input wire logic c_rise,
  input wire logic cb_rise,
  input wire logic c_strap,
  input wire logic dll_disable_n,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire logic [sram_port_pkg::LANES-1:0] byte_write_select_n,
  input wire logic q_oe
);
  // One domain, so clock and reset are declared once
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Steps of a transfer: read or write start on K rise, then four read words out
  sequence s_rd_start;
    k_rise && !read_port_select_n;
  endsequence
  sequence s_wr_start;
    k_rise && !write_port_select_n;
  endsequence
  sequence s_burst;
    q_oe [*4];
  endsequence
  property p_k_pair;
    k_rise |=> kb_rise && !k_rise;
  endproperty
  a_k_pair: assert property (p_k_pair) else $error("K pair out of step");
  property p_rd_on_k;
    !read_port_select_n |-> k_rise;
  endproperty
  a_rd_on_k: assert property (p_rd_on_k) else $error("read select off K rise");
  property p_wr_on_k;
    !write_port_select_n |-> k_rise;
  endproperty
  a_wr_on_k: assert property (p_wr_on_k) else $error("write select off K rise");
  property p_rd_spacing;
    s_rd_start |-> ##2 read_port_select_n;
  endproperty
  a_rd_spacing: assert property (p_rd_spacing) else $error("reads too close");
  property p_wr_spacing;
    s_wr_start |-> ##2 write_port_select_n;
  endproperty
  a_wr_spacing: assert property (p_wr_spacing) else $error("writes too close");
  property p_lat_dll;
    s_rd_start ##0 dll_disable_n |-> ##3 s_burst;
  endproperty
  a_lat_dll: assert property (p_lat_dll) else $error("read latency wrong");
  property p_lat_legacy;
    s_rd_start ##0 !dll_disable_n |-> ##2 s_burst;
  endproperty
  a_lat_legacy: assert property (p_lat_legacy) else $error("legacy latency wrong");
  // Release comes one cycle after the last of the four words
  property p_q_release;
    $fell(q_oe) |-> (dll_disable_n ? $past(read_port_select_n, 7) == 1'b0
                                   : $past(read_port_select_n, 6) == 1'b0);
  endproperty
  a_q_release: assert property (p_q_release) else $error("q released early");
  property p_lane_window;
    !(&byte_write_select_n) |-> !$past(write_port_select_n, 2) ||
      !$past(write_port_select_n, 3) || !$past(write_port_select_n, 4) ||
      !$past(write_port_select_n, 5);
  endproperty
  a_lane_window: assert property (p_lane_window) else $error("lane select outside data");
  property p_straps;
    $stable(dll_disable_n) && $stable(c_strap);
  endproperty
  a_straps: assert property (p_straps) else $error("strap moved in operation");
  property p_single_clk;
    c_strap |-> !c_rise && !cb_rise;
  endproperty
  a_single_clk: assert property (p_single_clk) else $error("C edges in single clock");
  c_legacy: cover property (s_rd_start ##0 !dll_disable_n);
endmodule : sram_port_sva

// ---- verilog/sram_ctrl_end.sv ----
`timescale 1ns/1ps
module sram_ctrl_end (
  input wire logic ref_clk,
  input wire logic rst_n,
  sram_port_if.ctl pins,
  input wire logic dll_off,
  input wire logic single_clk,
  input wire logic rd_req,
  input wire logic [sram_port_pkg::ADDR_W-1:0] rd_addr,
  output logic rd_ready,
  output logic [sram_port_pkg::BURST_W-1:0] rd_data,
  output logic rd_valid,
  input wire logic wr_req,
  input wire logic [sram_port_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [sram_port_pkg::BURST_W-1:0] wr_data,
  input wire logic [sram_port_pkg::BE_W-1:0] wr_byte_en,
  output logic wr_ready
);
  localparam int RW = sram_port_pkg::DATA_W;
  localparam int BW = sram_port_pkg::LANES;

  // All registered state of the controller end
  typedef struct packed {
    logic phase; // Low in a K rise cycle
    sram_port_pkg::start_t last; // Start at the previous K rise
    logic rsel_n; // Read select pin
    logic wsel_n; // Write select pin
    logic [sram_port_pkg::ADDR_W-1:0] addr;
    logic [BW-1:0] lane_n; // Byte lane select pins
    logic [RW-1:0] d;
    logic [sram_port_pkg::ADDR_W-1:0] wpend_a; // Write address for K-bar slot
    logic [sram_port_pkg::BURST_W-1:0] wpend; // Write burst waiting
    logic [sram_port_pkg::BE_W-1:0] wpend_be;
    logic [sram_port_pkg::BURST_W-1:0] wsend; // Words still to drive
    logic [sram_port_pkg::BE_W-1:0] wsend_be;
    logic [sram_port_pkg::IDX_W-1:0] wcnt; // Words left after current
    logic [1:0] wmark; // Write start age
    logic [sram_port_pkg::RMARK_W-1:0] rmark; // Read start age
    logic rc_active; // Capturing a read burst
    logic [sram_port_pkg::IDX_W-1:0] rc_idx;
    logic [sram_port_pkg::BURST_W-1:0] rbuf;
    logic [sram_port_pkg::BURST_W-1:0] rd_data;
    logic rd_valid;
  } ctl_state_t;

  ctl_state_t state_reg;
  ctl_state_t state_next;

  logic deciding; // Next cycle is a K rise
  logic do_rd;
  logic do_wr;
  logic cap_start;

  // Next state
  always_comb begin
    state_next = state_reg;
    state_next.phase = !state_reg.phase;
    state_next.rd_valid = 1'b0;
    // Starts are chosen one cycle ahead so the pins change before the K rise
    deciding = state_reg.phase;
    do_rd = deciding && rd_req && (state_reg.last != sram_port_pkg::START_READ);
    do_wr = deciding && wr_req && (state_reg.last != sram_port_pkg::START_WRITE) && !do_rd;
    if (deciding) begin
      state_next.rsel_n = !do_rd;
      state_next.wsel_n = !do_wr;
      if (do_rd) begin
        state_next.addr = rd_addr;
        state_next.last = sram_port_pkg::START_READ;
      end else if (do_wr) begin
        state_next.last = sram_port_pkg::START_WRITE;
      end else begin
        state_next.last = sram_port_pkg::START_NONE;
      end
      if (do_wr) begin
        state_next.wpend_a = wr_addr;
        state_next.wpend = wr_data;
        state_next.wpend_be = wr_byte_en;
      end
    end else begin
      // K-bar slot: selects released, write address on the shared pins
      state_next.rsel_n = 1'b1;
      state_next.wsel_n = 1'b1;
      if (state_reg.wmark[0]) begin
        state_next.addr = state_reg.wpend_a;
      end
    end
    state_next.wmark = {state_reg.wmark[0], do_wr};
    state_next.rmark = {state_reg.rmark[sram_port_pkg::RMARK_W-2:0], do_rd};
    // Write data follows at the next K rise, lowest word first
    if (state_reg.wmark[1]) begin
      state_next.d = state_reg.wpend[RW-1:0];
      state_next.lane_n = ~state_reg.wpend_be[BW-1:0];
      state_next.wsend = state_reg.wpend >> RW;
      state_next.wsend_be = state_reg.wpend_be >> BW;
      state_next.wcnt = sram_port_pkg::IDX_LAST;
    end else if (state_reg.wcnt != sram_port_pkg::IDX_FIRST) begin
      state_next.d = state_reg.wsend[RW-1:0];
      state_next.lane_n = ~state_reg.wsend_be[BW-1:0];
      state_next.wsend = state_reg.wsend >> RW;
      state_next.wsend_be = state_reg.wsend_be >> BW;
      state_next.wcnt = state_reg.wcnt - 1'b1;
    end else begin
      // No lane enabled outside a burst
      state_next.d = '0;
      state_next.lane_n = '1;
    end
    // Capture window starts at the latency set by the strap this end drives
    if (dll_off) begin
      cap_start = state_reg.rmark[sram_port_pkg::LAT_LEGACY_HALF];
    end else begin
      cap_start = state_reg.rmark[sram_port_pkg::LAT_DLL_HALF];
    end
    if (cap_start) begin
      state_next.rbuf[RW-1:0] = pins.q;
      state_next.rc_active = 1'b1;
      state_next.rc_idx = sram_port_pkg::IDX_FIRST + 1'b1;
    end else if (state_reg.rc_active) begin
      state_next.rbuf[state_reg.rc_idx*RW +: RW] = pins.q;
      state_next.rc_idx = state_reg.rc_idx + 1'b1;
      if (state_reg.rc_idx == sram_port_pkg::IDX_LAST) begin
        state_next.rc_active = 1'b0;
        state_next.rd_valid = 1'b1;
        state_next.rd_data = state_next.rbuf;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
      state_reg.rsel_n <= 1'b1;
      state_reg.wsel_n <= 1'b1;
      state_reg.lane_n <= '1;
    end else begin
      state_reg <= state_next;
    end
  end

  // K runs at half of ref_clk, well under the legacy ceiling
  assign pins.k_rise = !state_reg.phase;
  assign pins.kb_rise = state_reg.phase;
  // Single clock mode holds the C pair high, so it shows no edges
  assign pins.c_strap = single_clk;
  assign pins.c_rise = !single_clk && !state_reg.phase;
  assign pins.cb_rise = !single_clk && state_reg.phase;
  assign pins.dll_disable_n = !dll_off;
  assign pins.addr = state_reg.addr;
  assign pins.read_port_select_n = state_reg.rsel_n;
  assign pins.write_port_select_n = state_reg.wsel_n;
  assign pins.byte_write_select_n = state_reg.lane_n;
  assign pins.d = state_reg.d;
  assign rd_ready = do_rd;
  assign wr_ready = do_wr;
  assign rd_data = state_reg.rd_data;
  assign rd_valid = state_reg.rd_valid;
endmodule : sram_ctrl_end

// ---- verilog/sram_device_end.sv ----
`timescale 1ns/1ps
module sram_device_end (
  input wire logic ref_clk,
  input wire logic rst_n,
  sram_port_if.dev pins,
  output logic dll_locked,
  output logic single_cycle_latency_mode,
  output logic single_clock_mode,
  output logic read_ignored,
  output logic write_ignored
);
  // All registered state of the device end except the storage array
  typedef struct packed {
    logic taken; // Straps have been caught
    logic lat_legacy; // Delay loop off, one cycle latency
    logic single; // Outputs timed by the K pair
    sram_port_pkg::start_t last; // Start at previous K rise
    logic [sram_port_pkg::LOCK_W-1:0] lock_cnt; // K rises seen while locking
    logic locked; // Delay loop locked
    logic d1_v; // Read start, one cycle old
    logic [sram_port_pkg::ADDR_W-1:0] d1_a;
    logic d2_v; // Read start, two cycles old
    logic [sram_port_pkg::ADDR_W-1:0] d2_a;
    logic ob_active; // Read burst in progress
    logic [sram_port_pkg::IDX_W-1:0] ob_idx; // Next read word
    logic [sram_port_pkg::ADDR_W-1:0] ob_a; // Read burst address
    logic [sram_port_pkg::DATA_W-1:0] q; // Output register
    logic q_oe; // Output drive
    logic wr_arm; // Write started, address due on K-bar
    logic wq_v; // Write address queued
    logic [sram_port_pkg::ADDR_W-1:0] wq_a;
    logic wb_active; // Write burst in progress
    logic [sram_port_pkg::IDX_W-1:0] wb_idx; // Next write word
    logic [sram_port_pkg::ADDR_W-1:0] wb_a; // Write burst address
    logic rd_ign; // Read request dropped
    logic wr_ign; // Write request dropped
  } dev_state_t;

  dev_state_t state_reg;
  dev_state_t state_next;

  // Storage array, one word per transfer
  logic [sram_port_pkg::DATA_W-1:0] mem [0:sram_port_pkg::MEM_WORDS-1];

  logic mem_we; // Write one transfer this cycle
  logic [sram_port_pkg::WIDX_W-1:0] mem_widx; // Its array index
  logic [sram_port_pkg::WIDX_W-1:0] mem_ridx; // Word fetched for q
  logic out_tick; // Output register clock edge
  logic in_tick; // Any input clock edge
  logic rd_want; // Read select low at K rise
  logic wr_want; // Write select low at K rise
  logic go_rd; // Read accepted
  logic go_wr; // Write accepted
  logic start_v; // Read burst starts now
  logic [sram_port_pkg::ADDR_W-1:0] start_a; // Its address

  // Next state
  always_comb begin
    state_next = state_reg;
    mem_we = 1'b0;
    mem_widx = '0;
    mem_ridx = '0;
    // Straps are caught once after reset; a strap never changes in operation
    if (!state_reg.taken) begin
      state_next.taken = 1'b1;
      state_next.lat_legacy = !pins.dll_disable_n;
      state_next.single = pins.c_strap;
    end
    // Loop lock counts K rises only while the loop is on
    if (state_reg.taken && !state_reg.lat_legacy && !state_reg.locked && pins.k_rise) begin
      state_next.lock_cnt = state_reg.lock_cnt + 1'b1;
      if (state_reg.lock_cnt == sram_port_pkg::LOCK_LAST) begin
        state_next.locked = 1'b1;
      end
    end

    // Selects are only sampled at K rise, so starts line up with K
    in_tick = pins.k_rise || pins.kb_rise;
    rd_want = pins.k_rise && !pins.read_port_select_n;
    wr_want = pins.k_rise && !pins.write_port_select_n;
    // A port that started at the previous K rise is still busy
    go_rd = rd_want && (state_reg.last != sram_port_pkg::START_READ);
    go_wr = wr_want && (state_reg.last != sram_port_pkg::START_WRITE);
    // Both allowed only from idle: read wins and the write is dropped
    if (go_rd && go_wr) begin
      go_wr = 1'b0;
    end
    state_next.rd_ign = rd_want && !go_rd;
    state_next.wr_ign = wr_want && !go_wr;
    // Track the last start so that the two ports alternate
    if (pins.k_rise) begin
      if (go_rd) begin
        state_next.last = sram_port_pkg::START_READ;
      end else if (go_wr) begin
        state_next.last = sram_port_pkg::START_WRITE;
      end else begin
        state_next.last = sram_port_pkg::START_NONE;
      end
    end

    // Read address is taken in the K slot of the shared pins
    state_next.d1_v = go_rd;
    state_next.d1_a = pins.addr;
    state_next.d2_v = state_reg.d1_v;
    state_next.d2_a = state_reg.d1_a;

    // Output timing follows the K pair when the C pair is strapped high
    if (state_reg.single) begin
      out_tick = pins.k_rise || pins.kb_rise;
    end else begin
      out_tick = pins.c_rise || pins.cb_rise;
    end
    // The delay tap sets the latency: one cycle legacy, one and a half normal
    if (state_reg.lat_legacy) begin
      start_v = state_reg.d1_v;
      start_a = state_reg.d1_a;
    end else begin
      start_v = state_reg.d2_v;
      start_a = state_reg.d2_a;
    end
    // Read burst: four words on consecutive output edges
    if (out_tick) begin
      if (start_v) begin
        // First word of a new burst; reads are spaced so bursts never overlap
        mem_ridx = sram_port_pkg::word_index(start_a, sram_port_pkg::IDX_FIRST);
        state_next.q = mem[mem_ridx];
        state_next.q_oe = 1'b1;
        state_next.ob_active = 1'b1;
        state_next.ob_a = start_a;
        state_next.ob_idx = sram_port_pkg::IDX_FIRST + 1'b1;
      end else if (state_reg.ob_active) begin
        // Remaining words of the burst
        mem_ridx = sram_port_pkg::word_index(state_reg.ob_a, state_reg.ob_idx);
        state_next.q = mem[mem_ridx];
        state_next.ob_idx = state_reg.ob_idx + 1'b1;
        if (state_reg.ob_idx == sram_port_pkg::IDX_LAST) begin
          state_next.ob_active = 1'b0;
        end
      end else begin
        // Pending burst done: release the pins after the next edge
        state_next.q_oe = 1'b0;
      end
    end

    // Write burst: first word at the K rise after the address, then every edge
    if (pins.k_rise && state_reg.wq_v) begin
      mem_we = 1'b1;
      mem_widx = sram_port_pkg::word_index(state_reg.wq_a, sram_port_pkg::IDX_FIRST);
      state_next.wb_a = state_reg.wq_a;
      state_next.wb_idx = sram_port_pkg::IDX_FIRST + 1'b1;
      state_next.wb_active = 1'b1;
      state_next.wq_v = 1'b0;
    end else if (state_reg.wb_active && in_tick) begin
      mem_we = 1'b1;
      mem_widx = sram_port_pkg::word_index(state_reg.wb_a, state_reg.wb_idx);
      state_next.wb_idx = state_reg.wb_idx + 1'b1;
      if (state_reg.wb_idx == sram_port_pkg::IDX_LAST) begin
        state_next.wb_active = 1'b0;
      end
    end
    // Write address is taken in the K-bar slot of the shared pins
    if (go_wr) begin
      state_next.wr_arm = 1'b1;
    end else if (pins.kb_rise && state_reg.wr_arm) begin
      state_next.wr_arm = 1'b0;
      state_next.wq_v = 1'b1;
      state_next.wq_a = pins.addr;
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Array write; a deasserted byte select keeps the stored lane
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      for (int b = 0; b < sram_port_pkg::LANES; b++) begin
        if (!pins.byte_write_select_n[b]) begin
          mem[mem_widx][b*sram_port_pkg::BYTE_W +: sram_port_pkg::BYTE_W] <=
            pins.d[b*sram_port_pkg::BYTE_W +: sram_port_pkg::BYTE_W];
        end
      end
    end
  end

  // Pins and status, all from flip-flops
  assign pins.q = state_reg.q;
  assign pins.q_oe = state_reg.q_oe;
  assign dll_locked = state_reg.locked;
  assign single_cycle_latency_mode = state_reg.lat_legacy;
  assign single_clock_mode = state_reg.single;
  assign read_ignored = state_reg.rd_ign;
  assign write_ignored = state_reg.wr_ign;
endmodule : sram_device_end

// ---- verilog/sram_port_if.sv ----
`timescale 1ns/1ps
interface sram_port_if;
  logic k_rise; // K rising edge, one-cycle enable
  logic kb_rise; // K-bar rising edge, one-cycle enable
  logic c_rise; // C rising edge, one-cycle enable
  logic cb_rise; // C-bar rising edge, one-cycle enable
  logic c_strap; // Both C inputs tied high
  logic dll_disable_n; // Low turns the delay loop off
  logic [sram_port_pkg::ADDR_W-1:0] addr; // Shared address pins
  logic read_port_select_n; // Read select
  logic write_port_select_n; // Write select
  logic [sram_port_pkg::LANES-1:0] byte_write_select_n; // Byte lane enables
  logic [sram_port_pkg::DATA_W-1:0] d; // Write data pins
  logic [sram_port_pkg::DATA_W-1:0] q; // Read data pins
  logic q_oe; // High while the device drives q

  modport dev (
    input k_rise, kb_rise, c_rise, cb_rise, c_strap, dll_disable_n, addr,
    input read_port_select_n, write_port_select_n, byte_write_select_n, d,
    output q, q_oe
  );
  modport ctl (
    output k_rise, kb_rise, c_rise, cb_rise, c_strap, dll_disable_n, addr,
    output read_port_select_n, write_port_select_n, byte_write_select_n, d,
    input q, q_oe
  );
endinterface : sram_port_if

// ---- verilog/sram_port_pkg.sv ----
package sram_port_pkg;
  // Data path: narrow variant, two nine-bit byte lanes per transfer
  localparam int DATA_W = 18;
  localparam int LANES = 2;
  localparam int BYTE_W = 9;
  localparam int BURST = 4;
  localparam int IDX_W = 2;
  localparam int BURST_W = DATA_W * BURST;
  localparam int BE_W = LANES * BURST;
  // Modelled array depth in bursts; kept small on purpose
  localparam int ADDR_W = 8;
  localparam int WIDX_W = ADDR_W + IDX_W;
  localparam int MEM_WORDS = 1 << WIDX_W;
  localparam logic [IDX_W-1:0] IDX_FIRST = 2'h0;
  localparam logic [IDX_W-1:0] IDX_LAST = 2'h3;
  // Clocking: K runs at one half of ref_clk, so a half K cycle is one ref_clk cycle
  localparam int REF_CLK_MHZ = 25;
  localparam int K_DIV = 2;
  localparam int K_MHZ = REF_CLK_MHZ / K_DIV;
  localparam int LEGACY_FMAX_MHZ = 167;
  localparam bit K_RATE_OK = (K_MHZ <= LEGACY_FMAX_MHZ);
  // Read latency in half K cycles (ref_clk cycles) from the start edge
  localparam int LAT_DLL_HALF = 3;
  localparam int LAT_LEGACY_HALF = 2;
  localparam int RMARK_W = LAT_DLL_HALF + 1;
  // Delay loop lock time in K cycles
  localparam int DLL_LOCK_K_CYCLES = 1024;
  localparam int LOCK_W = 11;
  // Last count before lock, tied to the lock time so the two cannot drift apart
  localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(DLL_LOCK_K_CYCLES - 1);
  // Which port started at the previous K rise
  typedef enum logic [1:0] {START_NONE, START_READ, START_WRITE} start_t;

  // Array index of one transfer within a burst
  function automatic logic [WIDX_W-1:0] word_index(input logic [ADDR_W-1:0] a,
                                                   input logic [IDX_W-1:0] i);
    return {a, i};
  endfunction : word_index
endpackage : sram_port_pkg
